// *** inc/port_pkg.sv ***
// Purpose: shared constants and types for the port timing and pin sharing block
// Assumes: basic clock CLK at 50 MHz drives the instruction timing directly
// Notes: registers are 16 bits wide on an 8-bit byte address
package port_pkg;
	// instruction timing
	localparam logic [1:0] CLKS_PER_MCYCLE_LAST = 2'h3;
	localparam logic [1:0] MCYCLES_LAST = 2'h3;
	localparam logic [1:0] MC_FIRST = 2'h0;
	localparam logic [1:0] MC_THIRD = 2'h2;
	localparam logic [1:0] MC_FOURTH = 2'h3;
	localparam logic [1:0] SUB_FIRST = 2'h0;

	// register map
	localparam logic [7:0] CMD_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] INDATA_OFS = 8'h08;
	localparam logic [7:0] CONFIG_OFS = 8'h0c;

	// field positions
	localparam int CMD_DATA_LSB = 0;
	localparam int CMD_PORT_LSB = 4;
	localparam int CMD_DIR_BIT = 8;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_CNT1_BIT = 1;
	localparam int STAT_CNT2_BIT = 2;
	localparam int CFG_CNT1_BIT = 0;
	localparam int CFG_CNT2_BIT = 1;
	localparam int CFG_SER_BIT = 2;
	localparam int CFG_EXTCLK_BIT = 3;

	// port numbers carried by a command
	localparam logic [3:0] PORT_IN = 4'h0;
	localparam logic [3:0] PORT_OUT_A = 4'h1;
	localparam logic [3:0] PORT_OUT_B = 4'h2;
	localparam logic [3:0] PORT_BIDIR_FIRST = 4'h4;
	localparam logic [3:0] PORT_BIDIR_LAST = 4'h7;
	localparam logic [3:0] PORT_CTR = 4'h8;
	localparam logic [3:0] PORT_SER = 4'h9;

	// pin positions inside the shared ports, and the sink-only bidirectional port index
	localparam int CTR_ONE_BIT = 3;
	localparam int CTR_TWO_BIT = 1;
	localparam int SER_SCK_BIT = 2;
	localparam int SER_SO_BIT = 1;
	localparam int SER_SI_BIT = 0;
	localparam logic [1:0] BIDIR_SINK_ONLY_IDX = 2'h3;

	// circuit option codes
	localparam logic OPT_SINK = 1'b0;
	localparam logic OPT_SOURCE = 1'b1;

	// reset values
	localparam logic [3:0] LATCH_HIGH = 4'hf;
	localparam logic [3:0] LATCH_LOW = 4'h0;
	localparam logic [2:0] SER_LATCH_HIGH = 3'h7;
	localparam logic [3:0] CFG_RESET = 4'h0;

	typedef enum logic [1:0] {SEQ_IDLE, SEQ_ALIGN, SEQ_FIRST, SEQ_SECOND} seq_state_type;
endpackage

// *** logic/cycle_timer.sv ***
// Purpose: machine cycle and instruction cycle timing from the basic clock
// Assumes: CLK is the basic clock
// Notes: free running from reset release
`timescale 1ns/1ns
module cycle_timer (
	input wire logic CLK,
	input wire logic RSTN,
	output logic ic_start,
	output logic [1:0] mcycle,
	output logic [1:0] sub
);
	typedef struct packed {
		logic [1:0] mc;
		logic [1:0] sb;
	} timer_type;

	timer_type r, n;

	always_comb begin
		n = r;
		n.sb = r.sb + 2'h1; // [RULE4]
		if (r.sb == port_pkg::CLKS_PER_MCYCLE_LAST) begin
			n.mc = r.mc + 2'h1; // [RULE4]
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign mcycle = r.mc;
	assign sub = r.sb;
	assign ic_start = (r.mc == port_pkg::MC_FIRST) && (r.sb == port_pkg::SUB_FIRST);

	property p_icycle_len;
		@(posedge CLK) disable iff (!RSTN)
		ic_start |=> !ic_start [*8] ##8 ic_start;
	endproperty
	a_icycle_len: assert property (p_icycle_len) else $error("instruction cycle is not sixteen clocks"); // [RULE4]
endmodule

// *** logic/port_io.sv ***
// Purpose: port latches, pin timing of port instructions and pin sharing
// Assumes: one clock; core issues port instructions through the command register
// Notes: pin circuit option is a mask choice, fixed by parameter
// Functional notes
// RULE1 - input instructions sample pins in third machine cycle of second instruction cycle
// RULE2 - output instructions drive pins in fourth machine cycle of second instruction cycle
// RULE3 - port instructions take two instruction cycles, pins touched only in the second
// RULE4 - instruction cycle is four machine cycles of four basic clocks each
// RULE5 - sink open-drain output latches reset high, releasing the pin
// RULE6 - source option resets both dedicated output port latches low
// RULE7 - source option makes first three bidirectional ports output only
// RULE8 - two counter-port pins are general pins or the counter inputs
// RULE9 - rising edge on a counter input sets its count latch, requesting a count
// RULE10 - external driver holds counter input high and low over two instruction cycles
// RULE11 - serial-port pins are general pins or shift clock, serial out, serial in
// RULE12 - external shift clock holds each level over two instruction cycles
// RULE13 - system holds the test input low; the pin has a pull-down
// RULE14 - firmware leaves latches high on pins used as peripheral inputs
`timescale 1ns/1ns
module port_io #(
	parameter logic PIN_CIRCUIT_OPTION_CODE = port_pkg::OPT_SINK
) (
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic [7:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	input wire logic [3:0] INPUT_ONLY_PORT_I,
	output logic [3:0] DEDICATED_OUTPUT_PORT_A_O,
	output logic [3:0] DEDICATED_OUTPUT_PORT_A_OE,
	output logic [3:0] DEDICATED_OUTPUT_PORT_B_O,
	output logic [3:0] DEDICATED_OUTPUT_PORT_B_OE,
	input wire logic [15:0] BIDIR_PORTS_I,
	output logic [15:0] BIDIR_PORTS_O,
	output logic [15:0] BIDIR_PORTS_OE,
	input wire logic [3:0] SHARED_COUNTER_PORT_I,
	output logic [3:0] SHARED_COUNTER_PORT_O,
	output logic [3:0] SHARED_COUNTER_PORT_OE,
	input wire logic [2:0] SHARED_SERIAL_PORT_I,
	output logic [2:0] SHARED_SERIAL_PORT_O,
	output logic [2:0] SHARED_SERIAL_PORT_OE,
	output logic COUNTER_INPUT_ONE_REQ,
	output logic COUNTER_INPUT_TWO_REQ,
	input wire logic SHIFT_CLK_DRIVE,
	input wire logic SER_DATA_DRIVE,
	output logic SHIFT_CLK_SEEN,
	output logic SER_DATA_SEEN
);
	localparam logic SRC = (PIN_CIRCUIT_OPTION_CODE == port_pkg::OPT_SOURCE);
	localparam logic [3:0] DED_RESET = SRC ? port_pkg::LATCH_LOW : port_pkg::LATCH_HIGH;
	localparam logic [15:0] BIDIR_RESET = SRC ? {port_pkg::LATCH_HIGH, {3{port_pkg::LATCH_LOW}}}
		: {4{port_pkg::LATCH_HIGH}};

	typedef struct packed {
		port_pkg::seq_state_type state;
		logic [3:0] port;
		logic dir;
		logic [3:0] data;
		logic [3:0] indata;
		logic [3:0] out_a;
		logic [3:0] out_b;
		logic [15:0] bidir;
		logic [3:0] ctr;
		logic [2:0] ser;
		logic [3:0] cfg;
		logic cnt1;
		logic cnt2;
		logic [3:0] k_s1;
		logic [3:0] k_s2;
		logic [15:0] b_s1;
		logic [15:0] b_s2;
		logic [3:0] c_s1;
		logic [3:0] c_s2;
		logic [2:0] s_s1;
		logic [2:0] s_s2;
		logic [1:0] c_prev;
		logic [3:0] a_oe;
		logic [3:0] b_oe;
		logic [15:0] bid_oe;
		logic [3:0] ctr_oe;
		logic [2:0] ser_oe;
		logic [15:0] rdata;
	} state_type;

	state_type r, n;
	logic ic_start;
	logic [1:0] mcycle;
	logic [1:0] sub;
	logic sample_evt;
	logic drive_evt;
	logic rise1;
	logic rise2;
	logic [3:0] pin_val;
	logic [3:0] bid_pin;
	logic [3:0] bid_lat;

	cycle_timer timer (
		.CLK(CLK),
		.RSTN(RSTN),
		.ic_start(ic_start),
		.mcycle(mcycle),
		.sub(sub)
	);

	assign sample_evt = (r.state == port_pkg::SEQ_SECOND) && !r.dir && (mcycle == port_pkg::MC_THIRD)
		&& (sub == port_pkg::SUB_FIRST);
	assign drive_evt = (r.state == port_pkg::SEQ_SECOND) && r.dir && (mcycle == port_pkg::MC_FOURTH)
		&& (sub == port_pkg::SUB_FIRST);
	assign rise1 = r.cfg[port_pkg::CFG_CNT1_BIT] && r.c_s2[port_pkg::CTR_ONE_BIT] && !r.c_prev[1];
	assign rise2 = r.cfg[port_pkg::CFG_CNT2_BIT] && r.c_s2[port_pkg::CTR_TWO_BIT] && !r.c_prev[0];
	assign bid_pin = r.b_s2[{r.port[1:0], 2'b00} +: 4];
	assign bid_lat = r.bidir[{r.port[1:0], 2'b00} +: 4];

	always_comb begin
		n = r;
		pin_val = 4'h0;
		// two-stage synchronisers on every pin that is read
		n.k_s1 = INPUT_ONLY_PORT_I;
		n.k_s2 = r.k_s1;
		n.b_s1 = BIDIR_PORTS_I;
		n.b_s2 = r.b_s1;
		n.c_s1 = SHARED_COUNTER_PORT_I;
		n.c_s2 = r.c_s1;
		n.s_s1 = SHARED_SERIAL_PORT_I;
		n.s_s2 = r.s_s1;
		n.c_prev = {r.c_s2[port_pkg::CTR_ONE_BIT], r.c_s2[port_pkg::CTR_TWO_BIT]};

		// register writes; count latch clear first so a same-cycle edge wins
		if (WR) begin
			case (ADDR)
				port_pkg::CMD_OFS: begin
					if (r.state == port_pkg::SEQ_IDLE) begin
						n.data = WDATA[port_pkg::CMD_DATA_LSB +: 4];
						n.port = WDATA[port_pkg::CMD_PORT_LSB +: 4];
						n.dir = WDATA[port_pkg::CMD_DIR_BIT];
						n.state = port_pkg::SEQ_ALIGN;
					end
				end
				port_pkg::STATUS_OFS: begin
					if (WDATA[port_pkg::STAT_CNT1_BIT]) begin
						n.cnt1 = 1'b0;
					end
					if (WDATA[port_pkg::STAT_CNT2_BIT]) begin
						n.cnt2 = 1'b0;
					end
				end
				port_pkg::CONFIG_OFS: begin
					n.cfg = WDATA[3:0];
				end
				default: begin
				end
			endcase
		end
		if (rise1) begin
			n.cnt1 = 1'b1; // [RULE9] [RULE8]
		end
		if (rise2) begin
			n.cnt2 = 1'b1; // [RULE9] [RULE8]
		end

		// instruction sequence aligned to instruction cycle boundaries
		case (r.state)
			port_pkg::SEQ_IDLE: begin
			end
			port_pkg::SEQ_ALIGN: begin
				if (ic_start) begin
					n.state = port_pkg::SEQ_FIRST; // [RULE3]
				end
			end
			port_pkg::SEQ_FIRST: begin
				if (ic_start) begin
					n.state = port_pkg::SEQ_SECOND; // [RULE3]
				end
			end
			port_pkg::SEQ_SECOND: begin
				if (ic_start) begin
					n.state = port_pkg::SEQ_IDLE; // [RULE3]
				end
			end
			default: begin
				n.state = port_pkg::SEQ_IDLE;
			end
		endcase

		case (r.port)
			port_pkg::PORT_IN: pin_val = r.k_s2;
			port_pkg::PORT_OUT_A: pin_val = r.out_a;
			port_pkg::PORT_OUT_B: pin_val = r.out_b;
			port_pkg::PORT_CTR: pin_val = r.c_s2;
			port_pkg::PORT_SER: pin_val = {1'b0, r.s_s2};
			default: begin
				if (r.port >= port_pkg::PORT_BIDIR_FIRST && r.port <= port_pkg::PORT_BIDIR_LAST) begin
					// source-driven ports have no input path; read back the latch
					pin_val = (SRC && r.port[1:0] != port_pkg::BIDIR_SINK_ONLY_IDX) ? bid_lat : bid_pin; // [RULE7]
				end
			end
		endcase
		if (sample_evt) begin
			n.indata = pin_val; // [RULE1]
		end
		if (drive_evt) begin
			case (r.port)
				port_pkg::PORT_OUT_A: n.out_a = r.data; // [RULE2]
				port_pkg::PORT_OUT_B: n.out_b = r.data; // [RULE2]
				port_pkg::PORT_CTR: n.ctr = r.data; // [RULE2]
				port_pkg::PORT_SER: n.ser = r.data[2:0]; // [RULE2]
				default: begin
					if (r.port >= port_pkg::PORT_BIDIR_FIRST && r.port <= port_pkg::PORT_BIDIR_LAST) begin
						n.bidir[{r.port[1:0], 2'b00} +: 4] = r.data; // [RULE2]
					end
				end
			endcase
		end

		// pin enables follow the latches one clock later, still inside the same machine cycle
		n.a_oe = SRC ? r.out_a : ~r.out_a;
		n.b_oe = SRC ? r.out_b : ~r.out_b;
		n.bid_oe = SRC ? {~r.bidir[15:12], r.bidir[11:0]} : ~r.bidir; // [RULE7]
		// counter inputs share the sink driver; a low latch would mask the edges
		n.ctr_oe = ~r.ctr; // [RULE14] [RULE8]
		n.ser_oe = ~r.ser;
		if (r.cfg[port_pkg::CFG_SER_BIT]) begin
			n.ser_oe[port_pkg::SER_SO_BIT] = ~SER_DATA_DRIVE; // [RULE11]
			if (!r.cfg[port_pkg::CFG_EXTCLK_BIT]) begin
				n.ser_oe[port_pkg::SER_SCK_BIT] = ~SHIFT_CLK_DRIVE; // [RULE11]
			end
		end

		n.rdata = 16'h0000;
		if (RD) begin
			case (ADDR)
				port_pkg::CMD_OFS: n.rdata = {7'h00, r.dir, r.port, r.data};
				port_pkg::STATUS_OFS: n.rdata = {13'h0000, r.cnt2, r.cnt1, r.state != port_pkg::SEQ_IDLE};
				port_pkg::INDATA_OFS: n.rdata = {12'h000, r.indata};
				port_pkg::CONFIG_OFS: n.rdata = {12'h000, r.cfg};
				default: n.rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			r <= '0;
			r.state <= port_pkg::SEQ_IDLE;
			r.out_a <= DED_RESET; // [RULE5] [RULE6]
			r.out_b <= DED_RESET; // [RULE5] [RULE6]
			r.bidir <= BIDIR_RESET; // [RULE5]
			r.ctr <= port_pkg::LATCH_HIGH; // [RULE5]
			r.ser <= port_pkg::SER_LATCH_HIGH; // [RULE5]
			r.cfg <= port_pkg::CFG_RESET;
		end else begin
			r <= n;
		end
	end

	assign RDATA = r.rdata;
	assign DEDICATED_OUTPUT_PORT_A_O = {4{SRC}};
	assign DEDICATED_OUTPUT_PORT_A_OE = r.a_oe;
	assign DEDICATED_OUTPUT_PORT_B_O = {4{SRC}};
	assign DEDICATED_OUTPUT_PORT_B_OE = r.b_oe;
	assign BIDIR_PORTS_O = {4'h0, {12{SRC}}};
	assign BIDIR_PORTS_OE = r.bid_oe;
	assign SHARED_COUNTER_PORT_O = 4'h0;
	assign SHARED_COUNTER_PORT_OE = r.ctr_oe;
	assign SHARED_SERIAL_PORT_O = 3'h0;
	assign SHARED_SERIAL_PORT_OE = r.ser_oe;
	assign COUNTER_INPUT_ONE_REQ = r.cnt1;
	assign COUNTER_INPUT_TWO_REQ = r.cnt2;
	assign SHIFT_CLK_SEEN = r.s_s2[port_pkg::SER_SCK_BIT];
	assign SER_DATA_SEEN = r.s_s2[port_pkg::SER_SI_BIT];

	// helper for the checks below
	logic first_r;
	logic accept;
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			first_r <= 1'b1;
		end else begin
			first_r <= 1'b0;
		end
	end
	assign accept = WR && ADDR == port_pkg::CMD_OFS && r.state == port_pkg::SEQ_IDLE;

	property p_sample;
		@(posedge CLK) disable iff (!RSTN)
		sample_evt |=> r.indata == $past(pin_val);
	endproperty
	a_sample: assert property (p_sample) else $error("input not captured at third machine cycle"); // [RULE1]
	property p_drive;
		@(posedge CLK) disable iff (!RSTN)
		$changed(r.bidir) || $changed(r.out_a) |-> $past(drive_evt);
	endproperty
	a_drive: assert property (p_drive) else $error("latch changed outside fourth machine cycle"); // [RULE2]
	property p_two_cycles;
		@(posedge CLK) disable iff (!RSTN)
		accept |=> (r.state != port_pkg::SEQ_IDLE) [*8] ##[26:41] (r.state == port_pkg::SEQ_IDLE);
	endproperty
	a_two_cycles: assert property (p_two_cycles) else $error("port instruction length wrong"); // [RULE3]
	property p_sink_reset;
		@(posedge CLK) disable iff (!RSTN)
		first_r |-> r.ctr == port_pkg::LATCH_HIGH && r.bidir[15:12] == port_pkg::LATCH_HIGH && r.ctr_oe == 4'h0;
	endproperty
	a_sink_reset: assert property (p_sink_reset) else $error("sink latch not high after reset"); // [RULE5]
	property p_source_reset;
		@(posedge CLK) disable iff (!RSTN)
		first_r && SRC |-> r.out_a == port_pkg::LATCH_LOW && r.out_b == port_pkg::LATCH_LOW;
	endproperty
	a_source_reset: assert property (p_source_reset) else $error("dedicated latch not low at reset"); // [RULE6]
	property p_output_only;
		@(posedge CLK) disable iff (!RSTN)
		sample_evt && SRC && r.port == port_pkg::PORT_BIDIR_FIRST |=> r.indata == $past(r.bidir[3:0]);
	endproperty
	a_output_only: assert property (p_output_only) else $error("source port read its pin"); // [RULE7]
	property p_count_set;
		@(posedge CLK) disable iff (!RSTN)
		rise1 |=> COUNTER_INPUT_ONE_REQ;
	endproperty
	a_count_set: assert property (p_count_set) else $error("count latch missed a rising edge"); // [RULE9]
	property p_count_cause;
		@(posedge CLK) disable iff (!RSTN)
		$rose(COUNTER_INPUT_TWO_REQ) |-> $past(rise2) && $past(r.cfg[port_pkg::CFG_CNT2_BIT]);
	endproperty
	a_count_cause: assert property (p_count_cause) else $error("count request without selected edge"); // [RULE8]
	property p_serial_clk;
		@(posedge CLK) disable iff (!RSTN)
		r.cfg[port_pkg::CFG_SER_BIT] && !r.cfg[port_pkg::CFG_EXTCLK_BIT] && $stable(r.cfg)
		|=> SHARED_SERIAL_PORT_OE[port_pkg::SER_SCK_BIT] == !$past(SHIFT_CLK_DRIVE);
	endproperty
	a_serial_clk: assert property (p_serial_clk) else $error("shift clock pin not driven by shifter"); // [RULE11]
	c_input: cover property (@(posedge CLK) disable iff (!RSTN) sample_evt);
	c_output: cover property (@(posedge CLK) disable iff (!RSTN) drive_evt);
	c_count: cover property (@(posedge CLK) disable iff (!RSTN) $rose(COUNTER_INPUT_ONE_REQ));
endmodule

// *** testbench/port_io_bench.sv ***
// Purpose: self-checking bench for port_io under the sink option
// Assumes: outside circuitry from port_pins; one clock
// Notes: a second instance runs the source option on the same bus and outside sources
`timescale 1ns/1ns
module port_io_bench;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [15:0] wdata = 16'h0000;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic [15:0] rdata;
	logic [3:0] in_ext = 4'h0;
	logic [15:0] bidir_ext = 16'hffff;
	logic [3:0] ctr_ext = 4'h0;
	logic [2:0] ser_ext = 3'h7;
	logic sck_drv = 1'b1;
	logic sd_drv = 1'b1;
	logic [3:0] pa_o, pa_oe, pb_o, pb_oe, ctr_o, ctr_oe, ctr_pin;
	logic [15:0] bo, boe, bpin;
	logic [2:0] so, soe, spin;
	logic req1, req2, sck_seen, sd_seen;
	logic [3:0] qa_o, qa_oe, qb_o, qb_oe;
	logic [15:0] qo, qoe, qpin, rdata_src, rs;
	logic [23:0] oe_prev = 24'h000000;
	int errors = 0;
	int compares = 0;
	int cyc = 0;
	int chg = 0;
	int lat[16];
	int lsrc[16];
	always #10 clk = ~clk;
	port_io #(.PIN_CIRCUIT_OPTION_CODE(port_pkg::OPT_SINK)) dut (.CLK(clk), .RSTN(rstn), .ADDR(addr),
		.WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata), .INPUT_ONLY_PORT_I(in_ext),
		.DEDICATED_OUTPUT_PORT_A_O(pa_o), .DEDICATED_OUTPUT_PORT_A_OE(pa_oe),
		.DEDICATED_OUTPUT_PORT_B_O(pb_o), .DEDICATED_OUTPUT_PORT_B_OE(pb_oe),
		.BIDIR_PORTS_I(bpin), .BIDIR_PORTS_O(bo), .BIDIR_PORTS_OE(boe),
		.SHARED_COUNTER_PORT_I(ctr_pin), .SHARED_COUNTER_PORT_O(ctr_o), .SHARED_COUNTER_PORT_OE(ctr_oe),
		.SHARED_SERIAL_PORT_I(spin), .SHARED_SERIAL_PORT_O(so), .SHARED_SERIAL_PORT_OE(soe),
		.COUNTER_INPUT_ONE_REQ(req1), .COUNTER_INPUT_TWO_REQ(req2), .SHIFT_CLK_DRIVE(sck_drv),
		.SER_DATA_DRIVE(sd_drv), .SHIFT_CLK_SEEN(sck_seen), .SER_DATA_SEEN(sd_seen));
	port_pins ext (.bidir_o(bo), .bidir_oe(boe), .bidir_ext(bidir_ext), .bidir_pin(bpin), .ctr_o(ctr_o),
		.ctr_oe(ctr_oe), .ctr_ext(ctr_ext), .ctr_pin(ctr_pin), .ser_o(so), .ser_oe(soe), .ser_ext(ser_ext),
		.ser_pin(spin), .test_pin());
	// source option twin; its shared pins see the outside sources directly
	port_io #(.PIN_CIRCUIT_OPTION_CODE(port_pkg::OPT_SOURCE)) dut_src (.CLK(clk), .RSTN(rstn), .ADDR(addr),
		.WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata_src), .INPUT_ONLY_PORT_I(in_ext),
		.DEDICATED_OUTPUT_PORT_A_O(qa_o), .DEDICATED_OUTPUT_PORT_A_OE(qa_oe),
		.DEDICATED_OUTPUT_PORT_B_O(qb_o), .DEDICATED_OUTPUT_PORT_B_OE(qb_oe),
		.BIDIR_PORTS_I(qpin), .BIDIR_PORTS_O(qo), .BIDIR_PORTS_OE(qoe),
		.SHARED_COUNTER_PORT_I(ctr_ext), .SHARED_COUNTER_PORT_O(), .SHARED_COUNTER_PORT_OE(),
		.SHARED_SERIAL_PORT_I(ser_ext), .SHARED_SERIAL_PORT_O(), .SHARED_SERIAL_PORT_OE(),
		.COUNTER_INPUT_ONE_REQ(), .COUNTER_INPUT_TWO_REQ(), .SHIFT_CLK_DRIVE(sck_drv),
		.SER_DATA_DRIVE(sd_drv), .SHIFT_CLK_SEEN(), .SER_DATA_SEEN());
	assign qpin = (qoe & qo) | (~qoe & bidir_ext);
	// cycle of the last enable change, read settled after each edge
	always @(posedge clk) begin
		#1;
		cyc++;
		if ({pa_oe, pb_oe, boe} !== oe_prev) chg = cyc;
		oe_prev = {pa_oe, pb_oe, boe};
	end
	function automatic logic [23:0] exp_oe();
		exp_oe = {~4'(lat[1]), ~4'(lat[2]), ~4'(lat[7]), ~4'(lat[6]), ~4'(lat[5]), ~4'(lat[4])};
	endfunction
	// source drivers are on while the latch is high; port 7 stays a sink
	function automatic logic [23:0] exp_oe_src();
		exp_oe_src = {4'(lsrc[1]), 4'(lsrc[2]), ~4'(lsrc[7]), 4'(lsrc[6]), 4'(lsrc[5]), 4'(lsrc[4])};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// a strobe is lowered and an idle cycle follows, so tasks chain safely
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 d = rdata;
		rs = rdata_src;
		@(posedge clk);
	endtask
	task automatic wait_idle();
		logic [15:0] s;
		int n;
		n = 0;
		s = 16'h0001;
		while (s[0] !== 1'b0 && n < 40) begin
			rd(port_pkg::STATUS_OFS, s);
			n++;
		end
		check(32'(s[0]), 32'h0);
	endtask
	task automatic give_verdict();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		#400000;
		errors++;
		give_verdict();
	end
	initial begin
		logic [15:0] s;
		logic [3:0] a, b;
		int t0, ph, op[6], ip[5];
		op = '{1, 2, 4, 5, 6, 7};
		ip = '{0, 4, 5, 6, 7};
		void'($urandom(76890));
		foreach (lat[i]) lat[i] = 15;
		// source latches of the dedicated ports and ports 4 to 6 start low
		foreach (lsrc[i]) lsrc[i] = (i == 7) ? 15 : 0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		#1;
		check(32'({pa_oe, pb_oe, boe}), 32'h0);
		check(32'({pa_o, pb_o, bo, ctr_o, so}), 32'h0);
		check(32'({qa_oe, qb_oe, qoe}), 32'h0);
		check(32'({qa_o, qb_o, qo}), 32'h00ff0fff);
		check(32'({ctr_oe, soe, req1, req2}), 32'h0);
		rd(port_pkg::CONFIG_OFS, s);
		check(32'(s), 32'h0);
		rd(8'h10, s);
		check(32'(s), 32'h0);
		$display("reset test done");
		// start phase varies, the pin update phase must not
		foreach (op[i]) begin
			a = 4'($urandom_range(14));
			repeat ($urandom_range(15)) @(posedge clk);
			t0 = cyc;
			wr(port_pkg::CMD_OFS, {7'h0, 1'b1, 4'(op[i]), a});
			wait_idle();
			lat[op[i]] = a;
			lsrc[op[i]] = a;
			check(32'(chg - t0 >= 32 && chg - t0 <= 47), 32'h1);
			if (i == 0) ph = chg % 16;
			check(32'(chg % 16), 32'(ph));
			check(32'({pa_oe, pb_oe, boe}), 32'(exp_oe()));
			check(32'({qa_oe, qb_oe, qoe}), 32'(exp_oe_src()));
		end
		$display("output test done");
		// a level changed before the second instruction cycle is replaced; the later one is taken
		foreach (ip[i]) begin
			a = 4'($urandom);
			b = ~a;
			in_ext <= a;
			bidir_ext <= {4{a}};
			wr(port_pkg::CMD_OFS, {7'h0, 1'b0, 4'(ip[i]), 4'h0});
			repeat (8) @(posedge clk);
			in_ext <= b;
			bidir_ext <= {4{b}};
			wait_idle();
			in_ext <= a;
			bidir_ext <= {4{a}};
			rd(port_pkg::INDATA_OFS, s);
			check(32'(s[3:0]), 32'(ip[i] == 0 ? b : b & 4'(lat[ip[i]])));
			check(32'(rs[3:0]), 32'(ip[i] == 0 ? b : ip[i] == 7 ? b & 4'(lsrc[7]) : 4'(lsrc[ip[i]])));
		end
		$display("input test done");
		ctr_ext <= 4'hf;
		repeat (40) @(posedge clk);
		check(32'({req2, req1}), 32'h0);
		for (int k = 0; k < 2; k++) begin
			ctr_ext <= 4'h0;
			wr(port_pkg::CONFIG_OFS, 16'(1 << k));
			repeat (40) @(posedge clk);
			ctr_ext <= 4'hf;
			repeat (40) @(posedge clk);
			check(32'({req2, req1}), 32'(1 << k));
			rd(port_pkg::STATUS_OFS, s);
			check(32'(s[2:1]), 32'(1 << k));
			wr(port_pkg::STATUS_OFS, 16'h0006);
			@(posedge clk);
			check(32'({req2, req1}), 32'h0);
		end
		$display("counter test done");
		wr(port_pkg::CONFIG_OFS, 16'h0004);
		sd_drv <= 1'b0;
		sck_drv <= 1'b0;
		repeat (3) @(posedge clk);
		check(32'(soe), 32'h6);
		sd_drv <= 1'b1;
		wr(port_pkg::CONFIG_OFS, 16'h000c);
		for (int k = 0; k < 4; k++) begin
			a = 4'($urandom);
			ser_ext <= {a[0], 1'b1, a[1]};
			repeat (40) @(posedge clk);
			check(32'({sck_seen, sd_seen, soe}), 32'({a[0], a[1], 3'h0}));
		end
		$display("serial test done");
		give_verdict();
	end
endmodule

// *** testbench/port_pins.sv ***
// Purpose: outside circuitry seen by the port pins
// Assumes: a released pin shows the level of the outside source
// Notes: wired-and of device sink and outside source is left to the bench model
`timescale 1ns/1ns
module port_pins (
	input wire logic [15:0] bidir_o,
	input wire logic [15:0] bidir_oe,
	input wire logic [15:0] bidir_ext,
	output logic [15:0] bidir_pin,
	input wire logic [3:0] ctr_o,
	input wire logic [3:0] ctr_oe,
	input wire logic [3:0] ctr_ext,
	output logic [3:0] ctr_pin,
	input wire logic [2:0] ser_o,
	input wire logic [2:0] ser_oe,
	input wire logic [2:0] ser_ext,
	output logic [2:0] ser_pin,
	output logic test_pin
);
	// device wins where it drives, outside source elsewhere
	assign bidir_pin = (bidir_oe & bidir_o) | (~bidir_oe & bidir_ext);
	assign ctr_pin = (ctr_oe & ctr_o) | (~ctr_oe & ctr_ext);
	assign ser_pin = (ser_oe & ser_o) | (~ser_oe & ser_ext);
	// kept low, the pull-down alone would also do
	assign test_pin = 1'b0;
endmodule
